//--- common/dcfg_pkg.sv
// package for the converter input/output configuration register bank
// assumes a single 100 MHz clock domain and a simple register port
`default_nettype none
package dcfg_pkg;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 16;
  localparam logic [6:0] ADDR_FMT = 7'h02;
  localparam logic [6:0] ADDR_SCALE = 7'h03;
  localparam logic [6:0] ADDR_PAT = 7'h04;
  localparam logic [15:0] FMT_RESET = 16'h7000;
  localparam logic [15:0] SCALE_RESET = 16'hf000;
  localparam logic [15:0] FMT_WMASK = 16'hf0fa;
  localparam logic [15:0] SCALE_WMASK = 16'hf001;
  localparam logic [15:0] MID_SCALE = 16'h8000;
  localparam logic [15:0] SIGN_BIT = 16'h8000;
  localparam int unsigned B_WORD = 15;
  localparam int unsigned B_CCLK = 14;
  localparam int unsigned B_ICLK = 13;
  localparam int unsigned B_COLL = 12;
  localparam int unsigned B_SIF4 = 7;
  localparam int unsigned B_SHIFT = 6;
  localparam int unsigned B_BOOST = 5;
  localparam int unsigned B_OSC = 4;
  localparam int unsigned B_REV = 3;
  localparam int unsigned B_SIGN = 1;
  localparam int unsigned B_TX = 0;
  localparam int unsigned FS_HI = 15;
  localparam int unsigned FS_LO = 12;

  typedef struct packed {
    logic       word_wide_sel;
    logic       serial_four_wire_sel;
    logic       freq_shift_en;
    logic       shift_output_boost;
    logic       tuning_osc_en;
    logic       bus_bit_reverse;
    logic       signed_fmt_sel;
    logic [3:0] fullscale_step;
    logic [4:0] fullscale_mult;
    logic       transmit_en;
    logic       output_active;
  } dcfg_ctrl_t;

  typedef struct packed {
    logic conv_clk_lost;
    logic input_clk_lost;
    logic fifo_collide;
  } dcfg_alarm_t;
endpackage
`default_nettype wire

//--- design/dcfg_regs.sv
// register bank: input format, alarm shutdown, scale, transmit, pattern
// assumes alarms/clock monitor and data bus on i_clock; pins are synced
//
// Overview of operation
// - word_wide_sel selects full-word versus byte-wide input
// - conversion clock loss mutes outputs, enabled at reset
// - input clock loss mutes outputs when enabled
// - buffer collision alarm mutes outputs when enabled
// - serial_four_wire_sel picks four-line serial port
// - frequency-shift block active only while enabled
// - boost doubles frequency-shift output level
// - tuning oscillator runs only while enabled
// - bus_bit_reverse swaps input bit order
// - signed_fmt_sel picks two's complement or offset
// - fullscale_step sets current as step plus one
// - transmit enable is register or pin
// - each fail bit flags its data line
// - upper byte lines 15-8, lower 7-0
// - fail bits have no reset; write clears
// - reset loads 0x7000 and 0xF000
// - pattern check runs and forces outputs off
// - muted outputs carry mid-scale code 0x8000
`default_nettype none
module dcfg_regs
(
  input  wire logic                     i_clock,
  input  wire logic                     i_reset_n,
  input  wire logic                     i_wr_en,
  input  wire logic                     i_rd_en,
  input  wire logic [6:0]               i_addr,
  input  wire logic [15:0]              i_wdata,
  output logic      [15:0]              o_rdata,
  output logic                          o_rd_valid,
  input  wire logic                     i_transmit_en_pin,
  input  wire dcfg_pkg::dcfg_alarm_t    i_alarm,
  input  wire logic                     i_pattern_check_en,
  input  wire logic                     i_sample_valid,
  input  wire logic [15:0]              i_sample,
  input  wire logic [15:0]              i_expected,
  output dcfg_pkg::dcfg_ctrl_t          o_ctrl,
  output logic                          o_output_muted_alarm,
  output logic      [15:0]              o_data_i,
  output logic      [15:0]              o_data_q,
  input  wire logic [15:0]              i_data_i,
  input  wire logic [15:0]              i_data_q
);
  logic [15:0] fmt_q;
  logic [15:0] fmt_d;
  logic [15:0] scale_q;
  logic [15:0] scale_d;
  logic [15:0] pat_q;
  logic [15:0] pat_d;
  logic [1:0]  tx_pin_sync_q;
  logic [1:0]  tx_pin_sync_d;
  logic        muted_q;
  logic        muted_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic        rd_valid_q;
  logic [15:0] out_i_q;
  logic [15:0] out_q_q;
  logic [15:0] out_i_d;
  logic [15:0] out_q_d;

  wire sel_fmt = i_addr == dcfg_pkg::ADDR_FMT;
  wire sel_scale = i_addr == dcfg_pkg::ADDR_SCALE;
  wire sel_pat = i_addr == dcfg_pkg::ADDR_PAT;
  wire wr_fmt = i_wr_en && sel_fmt;
  wire wr_scale = i_wr_en && sel_scale;
  wire wr_pat = i_wr_en && sel_pat;

  // writable fields only; reserved bits stay zero
  assign fmt_d = wr_fmt ? (i_wdata & dcfg_pkg::FMT_WMASK) : fmt_q;
  assign scale_d = wr_scale ? (i_wdata & dcfg_pkg::SCALE_WMASK) : scale_q;

  // per-line mismatch, upper byte lines 15-8, lower byte 7-0
  wire [15:0] mismatch = i_sample ^ i_expected;
  wire [15:0] fail_now = (i_pattern_check_en && i_sample_valid)
                         ? mismatch : 16'h0000;
  // sticky; a new failure in the clearing cycle still sets its bit
  wire [15:0] pat_kept = wr_pat ? 16'h0000 : pat_q;
  assign pat_d = pat_kept | fail_now;

  // pin passes two flops before use
  assign tx_pin_sync_d = {tx_pin_sync_q[0], i_transmit_en_pin};
  wire tx_pin = tx_pin_sync_q[1];

  wire cclk_mute = fmt_q[dcfg_pkg::B_CCLK] && i_alarm.conv_clk_lost;
  wire iclk_mute = fmt_q[dcfg_pkg::B_ICLK] && i_alarm.input_clk_lost;
  wire coll_mute = fmt_q[dcfg_pkg::B_COLL] && i_alarm.fifo_collide;
  // masking lives outside this bank and is assumed clear
  assign muted_d = cclk_mute || iclk_mute || coll_mute;

  wire tx_en = scale_q[dcfg_pkg::B_TX] || tx_pin;
  wire active = tx_en && !i_pattern_check_en;

  // muted or disabled outputs idle at mid-scale, in step with the flag
  wire idle_out = muted_d || !active;
  assign out_i_d = idle_out ? dcfg_pkg::MID_SCALE : i_data_i;
  assign out_q_d = idle_out ? dcfg_pkg::MID_SCALE : i_data_q;

  assign rdata_d = sel_fmt ? fmt_q :
                   sel_scale ? scale_q :
                   sel_pat ? pat_q : 16'h0000;

  always_ff @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      fmt_q <= dcfg_pkg::FMT_RESET;
      scale_q <= dcfg_pkg::SCALE_RESET;
      tx_pin_sync_q <= 2'b00;
      muted_q <= 1'b0;
      rdata_q <= 16'h0000;
      rd_valid_q <= 1'b0;
      out_i_q <= dcfg_pkg::MID_SCALE;
      out_q_q <= dcfg_pkg::MID_SCALE;
    end
    else
    begin
      fmt_q <= fmt_d;
      scale_q <= scale_d;
      tx_pin_sync_q <= tx_pin_sync_d;
      muted_q <= muted_d;
      rdata_q <= i_rd_en ? rdata_d : rdata_q;
      rd_valid_q <= i_rd_en;
      out_i_q <= out_i_d;
      out_q_q <= out_q_d;
    end
  end

  // no reset for failure bits
  always_ff @(posedge i_clock)
  begin
    pat_q <= pat_d;
  end

  wire [3:0] fs_step = scale_q[dcfg_pkg::FS_HI:dcfg_pkg::FS_LO];

  assign o_ctrl.word_wide_sel = fmt_q[dcfg_pkg::B_WORD];
  assign o_ctrl.serial_four_wire_sel = fmt_q[dcfg_pkg::B_SIF4];
  assign o_ctrl.freq_shift_en = fmt_q[dcfg_pkg::B_SHIFT];
  // boost is a doubling of the shifter output
  assign o_ctrl.shift_output_boost = fmt_q[dcfg_pkg::B_BOOST];
  assign o_ctrl.tuning_osc_en = fmt_q[dcfg_pkg::B_OSC];
  assign o_ctrl.bus_bit_reverse = fmt_q[dcfg_pkg::B_REV];
  assign o_ctrl.signed_fmt_sel = fmt_q[dcfg_pkg::B_SIGN];
  assign o_ctrl.fullscale_step = fs_step;
  assign o_ctrl.fullscale_mult = {1'b0, fs_step} + 5'h01;
  assign o_ctrl.transmit_en = tx_en;
  assign o_ctrl.output_active = active && !muted_q;

  assign o_output_muted_alarm = muted_q;
  assign o_rdata = rdata_q;
  assign o_rd_valid = rd_valid_q;
  assign o_data_i = out_i_q;
  assign o_data_q = out_q_q;
endmodule
`default_nettype wire

//--- test/dcfg_host.sv
// host model: writes and reads the register bank
// assumes the bench calls acc; strobes move at the falling edge
`default_nettype none
module dcfg_host
(
  input  wire logic   i_clock,
  output logic        o_wr_en,
  output logic        o_rd_en,
  output logic [6:0]  o_addr,
  output logic [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // alarm masks are never set by this host
  initial {o_wr_en, o_rd_en, o_addr, o_wdata} = '0;
  task automatic acc(input logic wr, input logic [6:0] a,
                     input logic [15:0] d);
    @(negedge i_clock);
    {o_wr_en, o_rd_en, o_addr, o_wdata} = {wr, !wr, a, d};
    @(negedge i_clock);
    {o_wr_en, o_rd_en, o_wdata} = {2'h0, ~d};
  endtask
endmodule
`default_nettype wire

//--- test/dcfg_regs_sva.sv
// checker on the register bank ports
// bound below into every dcfg_regs
`default_nettype none
module dcfg_regs_sva
(
  input wire logic                  i_clock,
  input wire logic                  i_reset_n,
  input wire logic                  i_wr_en,
  input wire logic [6:0]            i_addr,
  input wire logic [15:0]           i_wdata,
  input wire logic                  i_pattern_check_en,
  input wire dcfg_pkg::dcfg_alarm_t i_alarm,
  input wire dcfg_pkg::dcfg_ctrl_t  o_ctrl,
  input wire logic                  o_output_muted_alarm,
  input wire logic [15:0]           o_data_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  sequence s_fmt;
    i_wr_en && i_addr == dcfg_pkg::ADDR_FMT;
  endsequence
  sequence s_scl;
    i_wr_en && i_addr == dcfg_pkg::ADDR_SCALE;
  endsequence
  a_word_mode: assert property (s_fmt |=>
    o_ctrl[17] == $past(i_wdata[15])) else $error("word mode");
  a_fmt_bits: assert property (s_fmt |=>
    o_ctrl[16:12] == $past(i_wdata[7:3])) else $error("fmt bits");
  a_signed_fmt: assert property (s_fmt |=>
    o_ctrl[11] == $past(i_wdata[1])) else $error("sign fmt");
  a_scale_write: assert property (s_scl |=>
    o_ctrl[10:7] == $past(i_wdata[15:12]) && o_ctrl[1] >= $past(i_wdata[0]))
    else $error("scale");
  a_step_mult: assert property (o_ctrl[6:2] == o_ctrl[10:7] + 5'h1)
    else $error("mult");
  a_reset_load: assert property ($rose(i_reset_n) |->
    o_ctrl[17:7] == 11'h00f) else $error("reset");
  a_mute_cause: assert property (o_output_muted_alarm |->
    $past(|i_alarm)) else $error("mute cause");
  a_mute_mid: assert property (o_output_muted_alarm |->
    o_data_i == dcfg_pkg::MID_SCALE) else $error("mute code");
  a_check_off: assert property (i_pattern_check_en [*2] |->
    !o_ctrl[0] ##1 o_data_i == dcfg_pkg::MID_SCALE) else $error("check");
endmodule
bind dcfg_regs dcfg_regs_sva u_sva (.*);
`default_nettype wire

//--- test/dcfg_regs_bench.sv
// bench: host model drives the bus, a queue holds expected reads
// assumes dcfg_host and the bound checker are compiled first
`default_nettype none
module dcfg_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk = 0, rst_n = 0, pin = 0, en = 0, vld = 0;
  logic                  wr, rd, rv, mu;
  logic [6:0]            a;
  logic [15:0]           wd, rdat, di, dq, v, smp = '0, pat = '0;
  logic [15:0]           xi = '0, xq = '0;
  logic [15:0]           notes[$];
  dcfg_pkg::dcfg_alarm_t alm = '0;
  dcfg_pkg::dcfg_ctrl_t  ctrl;
  int                    miscompares = 0, checks = 0;
  always #5 clk = ~clk;
  dcfg_host host (.i_clock(clk), .o_wr_en(wr), .o_rd_en(rd),
    .o_addr(a), .o_wdata(wd));
  dcfg_regs uut (.i_clock(clk), .i_reset_n(rst_n), .i_wr_en(wr),
    .i_rd_en(rd), .i_addr(a), .i_wdata(wd), .o_rdata(rdat),
    .o_rd_valid(rv), .i_transmit_en_pin(pin), .i_alarm(alm),
    .i_pattern_check_en(en), .i_sample_valid(vld), .i_sample(smp),
    .i_expected(pat), .o_ctrl(ctrl), .o_output_muted_alarm(mu),
    .o_data_i(di), .o_data_q(dq), .i_data_i(xi), .i_data_q(xq));
  task automatic chk(input string n, input logic [15:0] e, g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s exp %h seen %h", n, e, g);
    end
  endtask
  task automatic r(input logic [6:0] ad, input logic [15:0] e);
    notes.push_back(e);
    host.acc(1'b0, ad, '0);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(negedge clk)
    if (rv === 1'b1)
      chk("read", notes.pop_front(), rdat);
  initial
  begin
    #20us;
    miscompares++;
    report_and_stop;
  end
  initial
  begin
    void'($urandom(32'he9a6_30cf));
    xi = 16'($urandom);
    xq = 16'($urandom);
    cyc(10);
    rst_n = 1;
    r(dcfg_pkg::ADDR_FMT, dcfg_pkg::FMT_RESET);
    r(dcfg_pkg::ADDR_SCALE, dcfg_pkg::SCALE_RESET);
    r(7'h05, '0);
    repeat (4)
    begin
      v = 16'($urandom);
      host.acc(1'b1, dcfg_pkg::ADDR_FMT, v);
      r(dcfg_pkg::ADDR_FMT, v & dcfg_pkg::FMT_WMASK);
      host.acc(1'b1, dcfg_pkg::ADDR_SCALE, v);
      r(dcfg_pkg::ADDR_SCALE, v & dcfg_pkg::SCALE_WMASK);
    end
    host.acc(1'b1, dcfg_pkg::ADDR_SCALE, 16'hf000);
    cyc(4);
    chk("idle", dcfg_pkg::MID_SCALE, di);
    chk("idle q", dcfg_pkg::MID_SCALE, dq);
    pin = 1;
    cyc(4);
    chk("pin tx", xi, di);
    chk("pin tx q", xq, dq);
    pin = 0;
    host.acc(1'b1, dcfg_pkg::ADDR_SCALE, 16'hf001);
    cyc(4);
    chk("reg tx", xi, di);
    for (int k = 0; k < 3; k++)
    begin
      host.acc(1'b1, dcfg_pkg::ADDR_FMT, 16'h7000 ^ (16'h1000 << k));
      alm = 3'(1 << k);
      cyc(3);
      chk("unmuted", xi, di);
      chk("no mute flag", 16'h0000, {15'h0000, mu});
      host.acc(1'b1, dcfg_pkg::ADDR_FMT, 16'h7000);
      cyc(3);
      chk("muted", dcfg_pkg::MID_SCALE, di);
      chk("muted q", dcfg_pkg::MID_SCALE, dq);
      chk("mute flag", 16'h0001, {15'h0000, mu});
      alm = '0;
      cyc(3);
    end
    host.acc(1'b1, dcfg_pkg::ADDR_PAT, '0);
    r(dcfg_pkg::ADDR_PAT, '0);
    en = 1;
    pat = 16'($urandom);
    v = 16'($urandom) | 16'h0101;
    smp = pat ^ v;
    vld = 1;
    cyc(1);
    smp = pat;
    cyc(3);
    chk("check mode", dcfg_pkg::MID_SCALE, di);
    chk("check mode q", dcfg_pkg::MID_SCALE, dq);
    r(dcfg_pkg::ADDR_PAT, v);
    vld = 0;
    en = 0;
    host.acc(1'b1, dcfg_pkg::ADDR_PAT, 16'hffff);
    r(dcfg_pkg::ADDR_PAT, '0);
    cyc(2);
    report_and_stop;
  end
endmodule
`default_nettype wire
